// >>> gpd_pin_model.sv
// pin model: external drivers meeting the port outputs
`timescale 1ns/1ns
module gpd_pin_model
(
	input  wire gpd_pkg::gpd_pins_t pin_out,
	input  wire gpd_pkg::gpd_pins_t pin_oe,
	input  wire gpd_pkg::gpd_pins_t ext_drv,
	input  wire gpd_pkg::gpd_pins_t ext_hold,
	output gpd_pkg::gpd_pins_t      pin_lvl
);
	import gpd_pkg::*;
	// enabled bits show the port, the rest show the far side; held bits are pulled hard from outside
	assign pin_lvl = gpd_pins_t'((pin_out & pin_oe & ~ext_hold) | (ext_drv & (~pin_oe | ext_hold)));
endmodule

// >>> gpd_pkg.sv
// package for the two-port gpio data register block
package gpd_pkg;

	localparam int          GPD_ADDR_W         = 8;
	localparam int          GPD_DATA_W         = 8;
	localparam int          GPD_PORT_W         = 8;

	// register offsets
	localparam logic [7:0]  GPD_OFF_FIRST      = 8'h00;
	localparam logic [7:0]  GPD_OFF_SECOND     = 8'h01;
	localparam logic [7:0]  GPD_OFF_RSVD       = 8'h02;

	// reset values and fixed read values
	localparam logic [7:0]  GPD_RST_FIRST      = 8'h00;
	localparam logic [7:0]  GPD_RST_SECOND     = 8'h00;
	localparam logic [7:0]  GPD_RSVD_READ      = 8'h00;
	localparam logic [7:0]  GPD_UNMAPPED_READ  = 8'h00;

	// direction bit value that selects output
	localparam logic        GPD_DIR_OUT        = 1'b1;

	typedef struct packed {
		logic [GPD_ADDR_W-1:0] addr;
		logic [GPD_DATA_W-1:0] wdata;
		logic                  wr;
		logic                  rd;
	} gpd_req_t;

	typedef struct packed {
		logic [GPD_PORT_W-1:0] first_port_bits;
		logic [GPD_PORT_W-1:0] second_port_bits;
	} gpd_pins_t;

endpackage

// >>> gpd_port_data.sv
// two gpio port data registers with direction-dependent readback
`timescale 1ns/1ns

module gpd_port_data
(
	input  wire logic                          ref_clk,
	input  wire logic                          rst_b,
	input  wire gpd_pkg::gpd_req_t             bus_req,
	output logic [gpd_pkg::GPD_DATA_W-1:0]     bus_rdata,
	input  wire gpd_pkg::gpd_pins_t            dir_bits,
	input  wire gpd_pkg::gpd_pins_t            pin_in,
	output gpd_pkg::gpd_pins_t                 pin_out,
	output gpd_pkg::gpd_pins_t                 pin_oe
);
	import gpd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// readback mix: stored bit for outputs, pin level for inputs

	function automatic logic [GPD_PORT_W-1:0] gpd_mix
	(
		input logic [GPD_PORT_W-1:0] stored,
		input logic [GPD_PORT_W-1:0] pins,
		input logic [GPD_PORT_W-1:0] dir
	);
		gpd_mix = (stored & dir) | (pins & ~dir);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// data registers

	logic [GPD_PORT_W-1:0] first_port_data_ff;
	logic [GPD_PORT_W-1:0] second_port_data_ff;
	logic [GPD_PORT_W-1:0] nxt_first_port_data;
	logic [GPD_PORT_W-1:0] nxt_second_port_data;

	always_comb
	begin
		nxt_first_port_data  = first_port_data_ff;
		nxt_second_port_data = second_port_data_ff;
		// writes accepted in any mode; reserved and unmapped writes fall through
		if (bus_req.wr)
		begin
			if (bus_req.addr == GPD_OFF_FIRST)
			begin
				nxt_first_port_data = bus_req.wdata;
			end
			else if (bus_req.addr == GPD_OFF_SECOND)
			begin
				nxt_second_port_data = bus_req.wdata;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			first_port_data_ff  <= GPD_RST_FIRST;
			second_port_data_ff <= GPD_RST_SECOND;
		end
		else
		begin
			first_port_data_ff  <= nxt_first_port_data;
			second_port_data_ff <= nxt_second_port_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe; pin level sampled with the strobe

	logic [GPD_DATA_W-1:0] rdata_ff;
	logic [GPD_DATA_W-1:0] nxt_rdata;

	always_comb
	begin
		nxt_rdata = GPD_UNMAPPED_READ;
		if (bus_req.rd)
		begin
			unique case (bus_req.addr)
				GPD_OFF_FIRST:
				begin
					nxt_rdata = gpd_mix(first_port_data_ff, pin_in.first_port_bits,
						dir_bits.first_port_bits);
				end
				GPD_OFF_SECOND:
				begin
					nxt_rdata = gpd_mix(second_port_data_ff, pin_in.second_port_bits,
						dir_bits.second_port_bits);
				end
				GPD_OFF_RSVD:
				begin
					nxt_rdata = GPD_RSVD_READ;
				end
				default:
				begin
					nxt_rdata = GPD_UNMAPPED_READ;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			rdata_ff <= GPD_UNMAPPED_READ;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign bus_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////////////////
	// pins: data always presented, enable follows direction

	// one assignment per output so each struct has a single driver
	assign pin_out = '{first_port_bits: first_port_data_ff, second_port_bits: second_port_data_ff};
	assign pin_oe  = dir_bits;

	////////////////////////////////////////////////////////////////////////////////
	// checker helpers: address map test and a shadow copy of the data registers

	function automatic logic gpd_is_mapped
	(
		input logic [GPD_ADDR_W-1:0] addr
	);
		gpd_is_mapped = (addr == GPD_OFF_FIRST) || (addr == GPD_OFF_SECOND) || (addr == GPD_OFF_RSVD);
	endfunction

	// the shadow is built from the bus alone, so a stray update of a data register shows up at once
	logic [GPD_PORT_W-1:0] shadow_first_ff;
	logic [GPD_PORT_W-1:0] shadow_second_ff;
	logic [GPD_PORT_W-1:0] nxt_shadow_first;
	logic [GPD_PORT_W-1:0] nxt_shadow_second;

	always_comb
	begin
		nxt_shadow_first  = shadow_first_ff;
		nxt_shadow_second = shadow_second_ff;
		if (bus_req.wr && bus_req.addr == GPD_OFF_FIRST)
		begin
			nxt_shadow_first = bus_req.wdata;
		end
		if (bus_req.wr && bus_req.addr == GPD_OFF_SECOND)
		begin
			nxt_shadow_second = bus_req.wdata;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			shadow_first_ff  <= GPD_RST_FIRST;
			shadow_second_ff <= GPD_RST_SECOND;
		end
		else
		begin
			shadow_first_ff  <= nxt_shadow_first;
			shadow_second_ff <= nxt_shadow_second;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	AST_FIRST_WRITE: assert property (
		bus_req.wr && bus_req.addr == GPD_OFF_FIRST |=> first_port_data_ff == $past(bus_req.wdata))
		else $error("first port write not stored");

	AST_SECOND_WRITE: assert property (
		bus_req.wr && bus_req.addr == GPD_OFF_SECOND |=> second_port_data_ff == $past(bus_req.wdata))
		else $error("second port write not stored");

	AST_PIN_DRIVE: assert property (
		bus_req.wr && bus_req.addr == GPD_OFF_FIRST |=> pin_out.first_port_bits == $past(bus_req.wdata))
		else $error("first port pin not driven with written value");

	AST_READ_FIRST: assert property (
		bus_req.rd && bus_req.addr == GPD_OFF_FIRST |=> bus_rdata ==
		(($past(first_port_data_ff) & $past(dir_bits.first_port_bits))
		| ($past(pin_in.first_port_bits) & ~$past(dir_bits.first_port_bits))))
		else $error("first port readback source wrong");

	AST_READ_SECOND: assert property (
		bus_req.rd && bus_req.addr == GPD_OFF_SECOND |=> bus_rdata ==
		(($past(second_port_data_ff) & $past(dir_bits.second_port_bits))
		| ($past(pin_in.second_port_bits) & ~$past(dir_bits.second_port_bits))))
		else $error("second port readback source wrong");

	AST_RSVD_ZERO: assert property (
		bus_req.rd && bus_req.addr == GPD_OFF_RSVD |=> bus_rdata == 8'h00)
		else $error("reserved register read not zero");

	AST_RSVD_NO_EFFECT: assert property (
		bus_req.wr && bus_req.addr == GPD_OFF_RSVD |=> $stable(first_port_data_ff) && $stable(second_port_data_ff))
		else $error("reserved write changed a data register");

	AST_RESET_ZERO: assert property (@(posedge ref_clk) disable iff (1'b0)
		!rst_b |=> first_port_data_ff == 8'h00 && second_port_data_ff == 8'h00)
		else $error("data registers not cleared by reset");

	AST_HOLD: assert property (
		!bus_req.wr [*2] |-> $stable(first_port_data_ff) && $stable(second_port_data_ff))
		else $error("data register changed without a write");

	////////////////////////////////////////////////////////////////////////////////
	// checks: isolation between registers, unmapped space, reset of bus_rdata and pin_out

	AST_SHADOW_MATCH: assert property (
		first_port_data_ff == shadow_first_ff && second_port_data_ff == shadow_second_ff)
		else $error("data register differs from the value last written over the bus");

	AST_SECOND_PIN_DRIVE: assert property (
		bus_req.wr && bus_req.addr == GPD_OFF_SECOND |=> pin_out.second_port_bits == $past(bus_req.wdata))
		else $error("second port pin not driven with written value");

	AST_FIRST_KEEPS_SECOND: assert property (
		bus_req.wr && bus_req.addr == GPD_OFF_FIRST |=> $stable(second_port_data_ff))
		else $error("first port write disturbed the second port");

	AST_SECOND_KEEPS_FIRST: assert property (
		bus_req.wr && bus_req.addr == GPD_OFF_SECOND |=> $stable(first_port_data_ff))
		else $error("second port write disturbed the first port");

	AST_UNMAPPED_ZERO: assert property (
		bus_req.rd && !gpd_is_mapped(bus_req.addr) |=> bus_rdata == GPD_UNMAPPED_READ)
		else $error("unmapped read not zero");

	AST_UNMAPPED_NO_EFFECT: assert property (
		bus_req.wr && !gpd_is_mapped(bus_req.addr)
		|=> $stable(first_port_data_ff) && $stable(second_port_data_ff))
		else $error("unmapped write changed a data register");

	AST_RDATA_IDLE: assert property (
		!bus_req.rd |=> bus_rdata == GPD_UNMAPPED_READ)
		else $error("read data not back to zero after its cycle");

	AST_RESET_OUTPUTS: assert property (@(posedge ref_clk) disable iff (1'b0)
		!rst_b |=> bus_rdata == 8'h00 && pin_out == '0)
		else $error("read data or pins not cleared by reset");

	AST_WRITE_THEN_READ_FIRST: assert property (
		bus_req.wr && bus_req.addr == GPD_OFF_FIRST ##1 !bus_req.wr
		##1 bus_req.rd && bus_req.addr == GPD_OFF_FIRST && dir_bits.first_port_bits == 8'hff
		|=> bus_rdata == $past(bus_req.wdata, 3))
		else $error("first port read after a write did not return the new value");

	AST_WRITE_THEN_READ_SECOND: assert property (
		bus_req.wr && bus_req.addr == GPD_OFF_SECOND ##1 !bus_req.wr
		##1 bus_req.rd && bus_req.addr == GPD_OFF_SECOND && dir_bits.second_port_bits == 8'hff
		|=> bus_rdata == $past(bus_req.wdata, 3))
		else $error("second port read after a write did not return the new value");

	AST_READ_NO_SIDE_EFFECT: assert property (
		bus_req.rd && !bus_req.wr |=> $stable(first_port_data_ff) && $stable(second_port_data_ff))
		else $error("a read changed a data register");

	AST_READ_KEEPS_PINS: assert property (
		bus_req.rd && !bus_req.wr |=> $stable(pin_out))
		else $error("a read changed a port pin");

	////////////////////////////////////////////////////////////////////////////////
	// per-bit read source checks

	for (genvar bit_idx = 0; bit_idx < GPD_PORT_W; bit_idx++)
	begin : g_bit_chk
		AST_BIT_FIRST_SOURCE: assert property (
			bus_req.rd && bus_req.addr == GPD_OFF_FIRST |=> bus_rdata[bit_idx] ==
			(($past(dir_bits.first_port_bits[bit_idx]) == GPD_DIR_OUT) ? $past(first_port_data_ff[bit_idx])
			: $past(pin_in.first_port_bits[bit_idx])))
			else $error("first port read bit taken from the wrong source");

		AST_BIT_SECOND_SOURCE: assert property (
			bus_req.rd && bus_req.addr == GPD_OFF_SECOND |=> bus_rdata[bit_idx] ==
			(($past(dir_bits.second_port_bits[bit_idx]) == GPD_DIR_OUT) ? $past(second_port_data_ff[bit_idx])
			: $past(pin_in.second_port_bits[bit_idx])))
			else $error("second port read bit taken from the wrong source");
	end

	////////////////////////////////////////////////////////////////////////////////
	// cover points

	COV_WRITE_READ: cover property (bus_req.wr && bus_req.addr == GPD_OFF_FIRST ##1
		bus_req.rd && bus_req.addr == GPD_OFF_FIRST);
	COV_MIXED_DIR: cover property (bus_req.rd && bus_req.addr == GPD_OFF_SECOND
		&& dir_bits.second_port_bits != 8'h00 && dir_bits.second_port_bits != 8'hff);
	COV_RSVD_WRITE: cover property (bus_req.wr && bus_req.addr == GPD_OFF_RSVD);
	COV_PIN_OVERRIDE: cover property (bus_req.rd && bus_req.addr == GPD_OFF_FIRST
		&& (dir_bits.first_port_bits & (pin_in.first_port_bits ^ first_port_data_ff)) != 8'h00);
	COV_RESET_AFTER_WRITE: cover property (@(posedge ref_clk) disable iff (1'b0)
		!rst_b && first_port_data_ff != 8'h00);

endmodule

// >>> gpd_port_data_test.sv
// testbench for the two-port gpio data registers
`timescale 1ns/1ns
module gpd_port_data_test;
	import gpd_pkg::*;
	logic       ref_clk;
	logic       rst_b;
	gpd_req_t   req;
	logic [7:0] rdata;
	gpd_pins_t  dir;
	gpd_pins_t  ext;
	gpd_pins_t  hold;
	gpd_pins_t  lvl;
	gpd_pins_t  pout;
	gpd_pins_t  poe;
	int         error_cnt;
	int         compares;
	gpd_port_data dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .bus_req(req), .bus_rdata(rdata),
		.dir_bits(dir), .pin_in(lvl), .pin_out(pout), .pin_oe(poe));
	gpd_pin_model pin_u (.pin_out(pout), .pin_oe(poe), .ext_drv(ext), .ext_hold(hold), .pin_lvl(lvl));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, then fall to zero
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1 chk(rdata, exp);
		@(posedge ref_clk);
		#1 chk(rdata, 8'h00);
	endtask
	task give_verdict;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial
	begin
		#20000;
		error_cnt++;
		give_verdict();
	end
	initial
	begin
		error_cnt = 0;
		compares = 0;
		rst_b = 1'b0;
		req = '0;
		dir = '0;
		hold = '0;
		ext = '{first_port_bits: 8'h3c, second_port_bits: 8'hc3};
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		dir <= '{first_port_bits: 8'hff, second_port_bits: 8'hff};
		rd(GPD_OFF_FIRST, 8'h00);
		rd(GPD_OFF_SECOND, 8'h00);
		$display("test reset done");
		wr(GPD_OFF_FIRST, 8'ha5);
		rd(GPD_OFF_FIRST, 8'ha5);
		chk(pout.first_port_bits, 8'ha5);
		chk(poe.first_port_bits, 8'hff);
		wr(GPD_OFF_SECOND, 8'h5a);
		rd(GPD_OFF_SECOND, 8'h5a);
		chk(pout.second_port_bits, 8'h5a);
		$display("test output done");
		@(posedge ref_clk);
		dir <= '{first_port_bits: 8'h0f, second_port_bits: 8'hf0};
		rd(GPD_OFF_FIRST, 8'h35);
		chk(poe.second_port_bits, 8'hf0);
		rd(GPD_OFF_SECOND, 8'h53);
		wr(GPD_OFF_FIRST, 8'h81);
		rd(GPD_OFF_FIRST, 8'h31);
		@(posedge ref_clk);
		hold <= '{first_port_bits: 8'h01, second_port_bits: 8'h00};
		rd(GPD_OFF_FIRST, 8'h31);
		$display("test direction done");
		wr(GPD_OFF_RSVD, 8'hff);
		rd(GPD_OFF_RSVD, 8'h00);
		wr(8'h07, 8'hee);
		rd(8'h07, 8'h00);
		rd(GPD_OFF_FIRST, 8'h31);
		$display("test reserved done");
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(GPD_OFF_FIRST, 8'h30);
		rd(GPD_OFF_SECOND, 8'h03);
		chk(pout.first_port_bits, 8'h00);
		chk(pout.second_port_bits, 8'h00);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule
